// ---- common/seq_pkg.sv ----
/*
  package of the multi segment position sequencer: register map, field layout,
  reset values, mode encodings and timing counts.
  assumes a 100 MHz core clock and 32-bit classic wishbone.
*/
package seq_pkg;
  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ctrl_addr       = 8'h00;
  localparam logic [7:0] end_count_addr  = 8'h04;
  localparam logic [7:0] wait_time_addr  = 8'h08;
  localparam logic [7:0] status_addr     = 8'h0c;
  localparam logic [7:0] irq_status_addr = 8'h10;
  localparam logic [7:0] irq_mask_addr   = 8'h14;
  localparam logic [7:0] seg_base_addr   = 8'h40;
  localparam int         seg_max         = 16;

  // ----------------------------------------------------------------------
  // ctrl fields
  // ----------------------------------------------------------------------
  localparam int mode_lsb       = 0;
  localparam int resume_bit     = 2;
  localparam int unit_bit       = 3;
  localparam logic [1:0] mode_reset   = 2'h1;
  localparam logic       resume_reset = 1'b0;
  localparam logic       unit_reset   = 1'b0;
  localparam logic [4:0] end_count_reset = 5'h01;
  localparam logic [4:0] end_count_min   = 5'h01;
  localparam logic [4:0] end_count_max   = 5'h10;

  // run modes
  localparam logic [1:0] mode_single     = 2'h0;
  localparam logic [1:0] mode_cyclic     = 2'h1;
  localparam logic [1:0] mode_di_switch  = 2'h2;
  localparam logic [1:0] mode_sequential = 2'h3;
  localparam logic       resume_continue = 1'b0;
  localparam logic       resume_restart  = 1'b1;

  // interrupt bits
  localparam int irq_seg_done  = 0;
  localparam int irq_round_end = 1;
  localparam int irq_stopped   = 2;
  localparam int irq_width     = 3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int clk_mhz      = 100;
  localparam int ms_in_us     = 1000;
  localparam int ms_cycles    = clk_mhz * ms_in_us;
  localparam int s_in_ms      = 1000;

  typedef enum logic [2:0] {st_idle, st_run, st_decel, st_wait, st_servo_off, st_done} seq_state_e;
endpackage

// ---- dv/seq_loop_model.sv ----
/*
  position loop model: answers a segment start with a done pulse after len
  cycles and a stop request with one stopped pulse.
  assumes the sequencer clock and sync active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module seq_loop_model (
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  input  wire logic       start_in,
  input  wire logic       stop_in,
  input  wire logic [7:0] len_in,
  output logic            done_out,
  output logic            stopped_out
);
  logic [7:0] cnt;
  logic [2:0] sc;
  always @(posedge core_clk_in)
  begin
    done_out <= 1'b0;
    stopped_out <= 1'b0;
    if (!nrst_in)
    begin
      cnt <= 8'h00;
      sc <= 3'h0;
    end
    else if (stop_in)
    begin
      cnt <= 8'h00;
      if (sc != 3'h4) sc <= sc + 3'h1;
      stopped_out <= (sc == 3'h3);
    end
    else
    begin
      sc <= 3'h0;
      if (start_in) cnt <= len_in;
      else if (cnt != 8'h00)
      begin
        cnt <= cnt - 8'h01;
        done_out <= (cnt == 8'h01);
      end
    end
  end
endmodule // seq_loop_model
`default_nettype wire

// ---- dv/seq_monitor.sv ----
/*
  port checker of the multi segment position sequencer.
  assumes it is bound onto the sequencer top, one clock, sync active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module seq_monitor (
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic        seg_done_in,
  input wire logic        stopped_in,
  input wire logic        seg_start_out,
  input wire logic        seg_dir_out,
  input wire logic        decel_stop_out,
  input wire logic        servo_off_stop_out,
  input wire logic        positioning_complete_out
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  a_ack_follows_req:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("ack late");
  a_ack_one_pulse:
    assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
  a_dat_idle_zero:
    assert property (!wb_ack_out |-> wb_dat_out == 32'h0) else $error("read data without ack");
  a_start_clears_done:
    assert property (seg_start_out |-> !positioning_complete_out) else $error("complete at start");
  a_done_sets_complete:
    assert property (seg_done_in && !decel_stop_out && !servo_off_stop_out |=> positioning_complete_out)
      else $error("complete missing");
  a_dir_held_run:
    assert property (!seg_start_out |-> $stable(seg_dir_out)) else $error("direction changed");
  a_decel_holds:
    assert property (decel_stop_out && !stopped_in |=> decel_stop_out) else $error("decel dropped");
  a_decel_ends_done:
    assert property (decel_stop_out && stopped_in |=> !decel_stop_out && positioning_complete_out)
      else $error("no complete after stop");
  a_servo_off_low:
    assert property (servo_off_stop_out && stopped_in |=> !servo_off_stop_out ##0 !positioning_complete_out)
      else $error("complete after servo off");
endmodule // seq_monitor
`default_nettype wire

// ---- dv/test_multi_segment_position_sequencer.sv ----
/*
  self-checking bench of the multi segment position sequencer.
  assumes the loop model and the port checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module test_multi_segment_position_sequencer;
  import seq_pkg::*;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic        core_clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1;
  logic        wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out;
  logic [7:0]  wb_adr_in = 8'h00, len = 8'h06;
  logic [3:0]  wb_sel_in = 4'hf, seg_index_out;
  logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rd, seg_disp_out;
  logic        segment_run_enable_in = 1'b0, servo_enable_in = 1'b0, direction_select_input_in = 1'b0;
  logic        seg_done_in, stopped_in, seg_start_out, seg_dir_out, irq_out;
  logic        decel_stop_out, servo_off_stop_out, positioning_complete_out;
  int          fails = 0, checks_done = 0, cyc = 0, g, st;
  row_s        rows[16] = '{'{1'b0, ctrl_addr, 32'h0, 32'h1}, '{1'b0, end_count_addr, 32'h0, 32'h1},
    '{1'b0, wait_time_addr, 32'h0, 32'h0}, '{1'b0, status_addr, 32'h0, 32'h0},
    '{1'b0, irq_mask_addr, 32'h0, 32'h0}, '{1'b1, ctrl_addr, 32'h2, 32'h2},
    '{1'b1, ctrl_addr, 32'h3, 32'h3}, '{1'b1, ctrl_addr, 32'hf, 32'hf},
    '{1'b1, ctrl_addr, 32'h0, 32'h0}, '{1'b1, end_count_addr, 32'h10, 32'h10},
    '{1'b1, end_count_addr, 32'h11, 32'h10}, '{1'b1, end_count_addr, 32'h0, 32'h10},
    '{1'b1, end_count_addr, 32'h3, 32'h3}, '{1'b1, wait_time_addr, 32'h10002, 32'h2},
    '{1'b1, 8'h20, 32'h5, 32'h0}, '{1'b1, irq_mask_addr, 32'h7, 32'h7}};
  always #5 core_clk_in = ~core_clk_in;
  multi_segment_position_sequencer #(.disp_width(32), .ms_count(4)) i_dut (.core_clk_in, .nrst_in, .ce_in,
    .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .segment_run_enable_in, .servo_enable_in, .direction_select_input_in, .seg_done_in, .stopped_in,
    .seg_start_out, .seg_disp_out, .seg_dir_out, .decel_stop_out, .servo_off_stop_out,
    .positioning_complete_out, .seg_index_out, .irq_out);
  seq_loop_model i_loop (.core_clk_in, .nrst_in, .start_in(seg_start_out),
    .stop_in(decel_stop_out | servo_off_stop_out), .len_in(len), .done_out(seg_done_in), .stopped_out(stopped_in));
  // ----
  // helpers
  // ----
  task automatic tick;
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic pin(input logic r, input logic s);
    @(posedge core_clk_in);
    segment_run_enable_in <= r;
    servo_enable_in <= s;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return seg_start_out;
      1: return seg_done_in;
      2: return decel_stop_out;
      3: return servo_off_stop_out;
      default: return stopped_in;
    endcase
  endfunction
  task automatic wait_sig(input int s);
    g = 1;
    while (sig(s) !== 1'b1 && g < 500)
    begin
      tick;
      g++;
    end
    if (g >= 500) chk(32'h0, 32'h1);
  endtask
  task automatic results;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      results;
    end
  end
  // ----
  // tests
  // ----
  initial
  begin
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr) wb(1'b1, rows[i].a, rows[i].d);
      wb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    for (int n = 0; n < 4; n++) wb(1'b1, seg_base_addr + 8'(n * 4), 32'h100 * (n + 1));
    $display("test registers done");
    @(posedge core_clk_in) direction_select_input_in <= 1'b1;
    pin(1'b1, 1'b1);
    for (int n = 0; n < 3; n++)
    begin
      wait_sig(0);
      if (n > 0) chk(g > 4, 32'h1);
      chk(seg_index_out, n);
      chk(seg_disp_out, 32'h100 * (n + 1));
      chk(positioning_complete_out, 32'h0);
      @(posedge core_clk_in) direction_select_input_in <= 1'b0;
      wait_sig(1);
      tick;
      chk(positioning_complete_out, 32'h1);
      chk(seg_dir_out, n == 0);
    end
    st = 0;
    repeat (40)
    begin
      tick;
      st += seg_start_out;
    end
    chk(st, 0);
    chk(irq_out, 32'h1);
    wb(1'b0, irq_status_addr, 32'h0);
    chk(rd, 32'h3);
    wb(1'b1, irq_status_addr, 32'h3);
    tick;
    tick;
    chk(irq_out, 32'h0);
    $display("test single done");
    pin(1'b0, 1'b1);
    repeat (4) tick;
    wb(1'b1, ctrl_addr, 32'h1);
    wb(1'b1, wait_time_addr, 32'h0);
    wb(1'b1, end_count_addr, 32'h2);
    wb(1'b1, irq_mask_addr, 32'h0);
    pin(1'b1, 1'b1);
    for (int n = 0; n < 4; n++)
    begin
      wait_sig(0);
      chk(seg_index_out, n % 2);
      if (n > 0) chk(g, 32'h2);
      if (n == 3) break;
      wait_sig(1);
      tick;
      if (n == 2) len = 8'h1e;
    end
    chk(irq_out, 32'h0);
    $display("test cyclic done");
    pin(1'b0, 1'b1);
    wait_sig(2);
    wait_sig(4);
    tick;
    chk(positioning_complete_out, 32'h1);
    wb(1'b1, irq_mask_addr, 32'h4);
    tick;
    tick;
    chk(irq_out, 32'h1);
    wb(1'b1, irq_status_addr, 32'h7);
    pin(1'b1, 1'b1);
    wait_sig(0);
    chk(seg_index_out, 32'h1);
    pin(1'b0, 1'b1);
    wait_sig(4);
    tick;
    wb(1'b1, ctrl_addr, 32'h5);
    pin(1'b1, 1'b1);
    wait_sig(0);
    chk(seg_index_out, 32'h0);
    wait_sig(1);
    wait_sig(0);
    chk(seg_index_out, 32'h1);
    $display("test resume done");
    pin(1'b1, 1'b0);
    wait_sig(3);
    wait_sig(4);
    tick;
    chk(positioning_complete_out, 32'h0);
    chk(servo_off_stop_out, 32'h0);
    $display("test servo off done");
    @(posedge core_clk_in) nrst_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    tick;
    chk(positioning_complete_out, 32'h0);
    wb(1'b0, ctrl_addr, 32'h0);
    chk(rd, 32'h1);
    $display("test reset done");
    results;
  end
endmodule // test_multi_segment_position_sequencer
bind multi_segment_position_sequencer seq_monitor i_mon (.core_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in,
  .wb_ack_out, .wb_dat_out, .seg_done_in, .stopped_in, .seg_start_out, .seg_dir_out, .decel_stop_out,
  .servo_off_stop_out, .positioning_complete_out);
`default_nettype wire

// ---- logic/multi_segment_position_sequencer.sv ----
/*
  multi segment position sequencer: steps the axis through stored segments,
  wishbone register file, sticky interrupts.
  assumes the position loop answers a segment start with a done pulse and a
  stop request with a stopped pulse; pin inputs are asynchronous.
*/
// Summary of operation
// - run mode 0 runs one round of segments and then halts without restarting.
// - after a segment ends the segment index increments by itself.
// - in single mode a programmable wait is inserted between segments.
// - the run enable is a level; running proceeds only while it is held high.
// - positioning complete is raised when each segment completes.
// - dropping run enable mid segment discards the rest, decelerates, then raises complete.
// - on re-enable the start segment is chosen by the resume policy, except in run mode 2, where it always continues.
// - servo enable loss during a segment or deceleration stops the motor by the servo off method and leaves complete low.
// - direction select is latched at segment start and ignored while it runs.
// - one round runs segments 0 up to the end count minus 1 once each.
// - run mode codes: 0 single, 1 cyclic, 2 input switched, 3 sequential.
// - end count accepts 1 to 16 segments per round.
// - the wait applies only in modes 0 and 1, in ms or s units.
`timescale 1ns/1ps
`default_nettype none
module multi_segment_position_sequencer
  import seq_pkg::*;
#(
  parameter int disp_width = 32,
  parameter int ms_count   = seq_pkg::ms_cycles
)(
  input  wire logic                  core_clk_in,
  input  wire logic                  nrst_in,
  input  wire logic                  ce_in,
  input  wire logic                  wb_cyc_in,
  input  wire logic                  wb_stb_in,
  input  wire logic                  wb_we_in,
  input  wire logic [7:0]            wb_adr_in,
  input  wire logic [3:0]            wb_sel_in,
  input  wire logic [31:0]           wb_dat_in,
  output logic      [31:0]           wb_dat_out,
  output logic                       wb_ack_out,
  input  wire logic                  segment_run_enable_in,
  input  wire logic                  servo_enable_in,
  input  wire logic                  direction_select_input_in,
  input  wire logic                  seg_done_in,
  input  wire logic                  stopped_in,
  output logic                       seg_start_out,
  output logic      [disp_width-1:0] seg_disp_out,
  output logic                       seg_dir_out,
  output logic                       decel_stop_out,
  output logic                       servo_off_stop_out,
  output logic                       positioning_complete_out,
  output logic      [3:0]            seg_index_out,
  output logic                       irq_out
);
  import seq_pkg::*;

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  logic [1:0]            segment_run_mode;
  logic                  resume_policy;
  logic                  wait_time_unit;
  logic [4:0]            end_segment_count;
  logic [15:0]           wait_time;
  logic [disp_width-1:0] seg_mem [seg_max];
  logic [irq_width-1:0]  irq_status;
  logic [irq_width-1:0]  irq_mask;
  seq_state_e            state;
  logic [3:0]            idx;
  logic [15:0]           wait_cnt;
  logic                  round_end;
  logic                  interrupted;
  logic [2:0]            pins;
  logic                  run_en;
  logic                  servo_en;
  logic                  dir_sel;
  logic                  tick;

  seq_state_e            next_state;
  logic [3:0]            next_idx;
  logic [15:0]           next_wait_cnt;
  logic                  next_round_end;
  logic                  next_interrupted;
  logic                  next_start;
  logic                  next_dir;
  logic                  next_complete;
  logic [irq_width-1:0]  ev;

  seq_sync #(.width(3)) u_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .ce_in       (ce_in),
    .d_in        ({segment_run_enable_in, servo_enable_in, direction_select_input_in}),
    .q_out       (pins)
  );
  assign run_en   = pins[2];
  assign servo_en = pins[1];
  assign dir_sel  = pins[0];

  seq_tick #(.ms_count(ms_count)) u_tick (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .ce_in       (ce_in),
    .run_in      (state == st_wait),
    .unit_in     (wait_time_unit),
    .tick_out    (tick)
  );

  function automatic logic [3:0] last_index(input logic [4:0] cnt);
    last_index = 4'(cnt - 5'h01);
  endfunction

  function automatic logic wait_applies(input logic [1:0] mode);
    wait_applies = (mode == mode_single) || (mode == mode_cyclic);
  endfunction

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_idx       = idx;
    next_wait_cnt  = wait_cnt;
    next_round_end = round_end;
    next_interrupted = interrupted;
    next_start     = 1'b0;
    next_dir       = seg_dir_out;
    next_complete  = positioning_complete_out;
    ev             = '0;
    unique case (state)
      st_idle, st_done:
      begin
        if (run_en && servo_en && !(state == st_done && round_end))
        begin
          // restart policy
          // policy only applies to a resume after an abandoned run, not to normal stepping
          if (interrupted && resume_policy == resume_restart && segment_run_mode != mode_di_switch)
            next_idx = '0;
          next_interrupted = 1'b0;
          next_round_end = 1'b0;
          next_start     = 1'b1;
          next_dir       = dir_sel;
          next_complete  = 1'b0;
          next_state     = st_run;
        end
        else if (state == st_done && !run_en)
          next_round_end = 1'b0;
      end
      st_run:
      begin
        if (!servo_en)
        begin
          next_state = st_servo_off;
        end
        else if (!run_en)
        begin
          next_state = st_decel;
        end
        else if (seg_done_in)
        begin
          next_complete = 1'b1;
          ev[irq_seg_done] = 1'b1;
          if (idx >= last_index(end_segment_count))
          begin
            next_idx = '0;
            ev[irq_round_end] = 1'b1;
            if (segment_run_mode == mode_single)
            begin
              next_round_end = 1'b1;
              next_state     = st_done;
            end
            else
              next_state = st_wait;
          end
          else
          begin
            next_idx   = idx + 4'h1;
            next_state = st_wait;
          end
          next_wait_cnt = wait_time;
          // wait only in modes 0 and 1
          if (next_state == st_wait && (!wait_applies(segment_run_mode) || wait_time == '0))
          begin
            next_state = st_idle;
          end
        end
      end
      st_wait:
      begin
        if (!servo_en || !run_en)
        begin
          next_state       = st_idle;
          next_interrupted = 1'b1;
        end
        else if (tick)
        begin
          next_wait_cnt = wait_cnt - 16'h0001;
          if (wait_cnt == 16'h0001)
            next_state = st_idle;
        end
      end
      st_decel:
      begin
        next_interrupted = 1'b1;
        if (!servo_en)
          next_state = st_servo_off;
        else if (stopped_in)
        begin
          next_complete = 1'b1;
          ev[irq_stopped] = 1'b1;
          next_state = st_done;
        end
      end
      st_servo_off:
      begin
        next_interrupted = 1'b1;
        if (stopped_in)
        begin
          next_complete = 1'b0;
          ev[irq_stopped] = 1'b1;
          next_state = st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      state                    <= st_idle;
      idx                      <= '0;
      wait_cnt                 <= '0;
      round_end                <= 1'b0;
      interrupted              <= 1'b0;
      seg_start_out            <= 1'b0;
      seg_dir_out              <= 1'b0;
      positioning_complete_out <= 1'b0;
      decel_stop_out           <= 1'b0;
      servo_off_stop_out       <= 1'b0;
      seg_index_out            <= '0;
      seg_disp_out             <= '0;
    end
    else if (ce_in)
    begin
      state                    <= next_state;
      idx                      <= next_idx;
      wait_cnt                 <= next_wait_cnt;
      round_end                <= next_round_end;
      interrupted              <= next_interrupted;
      seg_start_out            <= next_start;
      seg_dir_out              <= next_dir;
      positioning_complete_out <= next_complete;
      decel_stop_out           <= (next_state == st_decel);
      servo_off_stop_out       <= (next_state == st_servo_off);
      seg_index_out            <= next_idx;
      seg_disp_out             <= seg_mem[next_idx];
    end
  end

  // ----------------------------------------------------------------------
  // wishbone slave and interrupts
  // ----------------------------------------------------------------------
  logic                 req;
  logic                 wr;
  logic [31:0]          rdata;
  logic [irq_width-1:0] next_irq_status;

  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr  = req && wb_we_in;

  always_comb
  begin
    rdata = 32'h0000_0000;
    if (wb_adr_in >= seg_base_addr)
      rdata = 32'(seg_mem[wb_adr_in[5:2]]);
    else
      unique case (wb_adr_in)
        ctrl_addr:       rdata = {28'h0, wait_time_unit, resume_policy, segment_run_mode};
        end_count_addr:  rdata = {27'h0, end_segment_count};
        wait_time_addr:  rdata = {16'h0, wait_time};
        status_addr:     rdata = {24'h0, positioning_complete_out, 3'(state), idx};
        irq_status_addr: rdata = {29'h0, irq_status};
        irq_mask_addr:   rdata = {29'h0, irq_mask};
        default:         rdata = 32'h0000_0000;
      endcase
    // set wins over write-one-clear
    next_irq_status = irq_status | ev;
    if (wr && wb_adr_in == irq_status_addr && wb_sel_in[0])
      next_irq_status = (irq_status & ~wb_dat_in[irq_width-1:0]) | ev;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      wb_ack_out        <= 1'b0;
      wb_dat_out        <= '0;
      segment_run_mode  <= mode_reset;
      resume_policy     <= resume_reset;
      wait_time_unit    <= unit_reset;
      end_segment_count <= end_count_reset;
      wait_time         <= '0;
      irq_status        <= '0;
      irq_mask          <= '0;
      irq_out           <= 1'b0;
    end
    else if (ce_in)
    begin
      wb_ack_out <= req;
      wb_dat_out <= req ? rdata : 32'h0000_0000;
      irq_status <= next_irq_status;
      irq_out    <= |(next_irq_status & irq_mask);
      if (wr && wb_sel_in[0])
      begin
        unique case (wb_adr_in)
          ctrl_addr:
          begin
            segment_run_mode <= wb_dat_in[mode_lsb +: 2];
            resume_policy    <= wb_dat_in[resume_bit];
            wait_time_unit   <= wb_dat_in[unit_bit];
          end
          end_count_addr:
            if (wb_dat_in[4:0] >= end_count_min && wb_dat_in[4:0] <= end_count_max)
              end_segment_count <= wb_dat_in[4:0];
          irq_mask_addr:   irq_mask <= wb_dat_in[irq_width-1:0];
          default:
          begin
          end
        endcase
      end
      if (wr && wb_adr_in == wait_time_addr && wb_sel_in[1:0] == 2'h3)
        wait_time <= wb_dat_in[15:0];
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (ce_in && wr && wb_adr_in >= seg_base_addr && wb_sel_in == 4'hf)
      seg_mem[wb_adr_in[5:2]] <= wb_dat_in[disp_width-1:0];
  end
endmodule // multi_segment_position_sequencer
`default_nettype wire

// ---- logic/seq_sync.sv ----
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes the core clock and synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module seq_sync #(
  parameter int width = 3
)(
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  input  wire logic [width-1:0] d_in,
  output logic      [width-1:0] q_out
);
  logic [width-1:0] meta;

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      meta  <= '0;
      q_out <= '0;
    end
    else if (ce_in)
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // seq_sync
`default_nettype wire

// ---- logic/seq_tick.sv ----
/*
  time base: one pulse per millisecond, or per second when unit is set.
  assumes the core clock and synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module seq_tick
  import seq_pkg::*;
#(
  parameter int ms_count = ms_cycles,
  parameter int s_count  = s_in_ms
)(
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  input  wire logic run_in,
  input  wire logic unit_in,
  output logic      tick_out
);
  logic [16:0] cyc;
  logic [9:0]  msc;
  logic [16:0] next_cyc;
  logic [9:0]  next_msc;
  logic        next_tick;

  always_comb
  begin
    next_cyc  = cyc;
    next_msc  = msc;
    next_tick = 1'b0;
    if (!run_in)
    begin
      next_cyc = '0;
      next_msc = '0;
    end
    else if (cyc == 17'(ms_count - 1))
    begin
      next_cyc = '0;
      if (!unit_in)
        next_tick = 1'b1;
      else if (msc == 10'(s_count - 1))
      begin
        next_msc  = '0;
        next_tick = 1'b1;
      end
      else
        next_msc = msc + 10'h001;
    end
    else
      next_cyc = cyc + 17'h00001;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      cyc      <= '0;
      msc      <= '0;
      tick_out <= 1'b0;
    end
    else if (ce_in)
    begin
      cyc      <= next_cyc;
      msc      <= next_msc;
      tick_out <= next_tick;
    end
  end
endmodule // seq_tick
`default_nettype wire
